//--- include/gpio_pkg.sv
// Overview of operation
// (RQ1) function-select bit 1 hands the pin to its serial unit, 0 keeps it GPIO
// (RQ2) a GPIO pin is an output when its direction bit is 1, input when 0
// (RQ3) reading a GPIO input's data bit returns the level on the pin
// (RQ4) a GPIO output drives the value last written into its data bit
// (RQ5) software writes zero to every reserved bit of all nine registers
// (RQ6) reset clears every register, so all pins start as GPIO inputs
// (RQ7) ports C and D have six pins, bit n drives pin n, bits 6-23 reserved
// (RQ8) port E has three pins on bits 0-2, higher bits reserved and read zero
package gpio_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 24;
    localparam int PIN_W = 6;
    localparam int NPORT = 3;
    localparam int SYNC_DEPTH = 2;

    localparam logic [1:0] PORT_C = 2'h0;
    localparam logic [1:0] PORT_D = 2'h1;
    localparam logic [1:0] PORT_E = 2'h2;

    localparam logic [23:0] PORT_C_FUNCTION_SELECT_ADDR = 24'h0f_ffbf;
    localparam logic [23:0] PORT_C_DIRECTION_ADDR = 24'hff_ffbe;
    localparam logic [23:0] PORT_C_PIN_DATA_ADDR = 24'hff_ffbd;
    localparam logic [23:0] PORT_D_FUNCTION_SELECT_ADDR = 24'hff_ffaf;
    localparam logic [23:0] PORT_D_DIRECTION_ADDR = 24'hff_ffae;
    localparam logic [23:0] PORT_D_PIN_DATA_ADDR = 24'hff_ffad;
    localparam logic [23:0] PORT_E_FUNCTION_SELECT_ADDR = 24'hff_ff9f;
    localparam logic [23:0] PORT_E_DIRECTION_ADDR = 24'hff_ff9e;
    localparam logic [23:0] PORT_E_PIN_DATA_ADDR = 24'hff_ff9d;

    localparam logic [23:0] REG_RESET = 24'h00_0000;
    localparam logic [5:0] PIN_RESET = 6'h00;
    localparam logic [5:0] WIDE_PORT_MASK = 6'h3f;
    localparam logic [5:0] NARROW_PORT_MASK = 6'h07;

    typedef enum logic [1:0] {
        REG_FSEL = 2'b00,
        REG_DIR = 2'b01,
        REG_DATA = 2'b10,
        REG_NONE = 2'b11
    } reg_sel_e;

    typedef struct packed {
        logic [5:0] fsel;
        logic [5:0] dir;
        logic [5:0] data;
    } port_regs_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [23:0] addr;
        logic [23:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic hit;
        logic [1:0] port;
        reg_sel_e sel;
    } reg_hit_s;
endpackage

//--- hdl/shared_serial_pin_gpio_ports.sv
module shared_serial_pin_gpio_ports (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // core register port
    input wire gpio_pkg::bus_req_s bus_req,
    output logic [23:0] bus_rdata,
    output logic bus_rvalid,
    // pads: [port][pin], port 0 = C, 1 = D, 2 = E
    input wire logic [2:0][5:0] pin_in,
    output logic [2:0][5:0] pin_out,
    output logic [2:0][5:0] pin_oe_n,
    // serial unit side
    input wire logic [2:0][5:0] periph_out,
    input wire logic [2:0][5:0] periph_oe,
    output logic [2:0][5:0] periph_in
);
    function automatic logic [5:0] port_mask(input logic [1:0] p);
        port_mask = (p == gpio_pkg::PORT_E) ? gpio_pkg::NARROW_PORT_MASK
                                            : gpio_pkg::WIDE_PORT_MASK; // [RQ7] [RQ8]
    endfunction

    function automatic gpio_pkg::reg_hit_s decode(input logic [23:0] a);
        decode = '{hit: 1'b1, port: gpio_pkg::PORT_C, sel: gpio_pkg::REG_NONE};
        case (a)
            gpio_pkg::PORT_C_FUNCTION_SELECT_ADDR: decode.sel = gpio_pkg::REG_FSEL;
            gpio_pkg::PORT_C_DIRECTION_ADDR: decode.sel = gpio_pkg::REG_DIR;
            gpio_pkg::PORT_C_PIN_DATA_ADDR: decode.sel = gpio_pkg::REG_DATA;
            gpio_pkg::PORT_D_FUNCTION_SELECT_ADDR: begin
                decode.port = gpio_pkg::PORT_D;
                decode.sel = gpio_pkg::REG_FSEL;
            end
            gpio_pkg::PORT_D_DIRECTION_ADDR: begin
                decode.port = gpio_pkg::PORT_D;
                decode.sel = gpio_pkg::REG_DIR;
            end
            gpio_pkg::PORT_D_PIN_DATA_ADDR: begin
                decode.port = gpio_pkg::PORT_D;
                decode.sel = gpio_pkg::REG_DATA;
            end
            gpio_pkg::PORT_E_FUNCTION_SELECT_ADDR: begin
                decode.port = gpio_pkg::PORT_E;
                decode.sel = gpio_pkg::REG_FSEL;
            end
            gpio_pkg::PORT_E_DIRECTION_ADDR: begin
                decode.port = gpio_pkg::PORT_E;
                decode.sel = gpio_pkg::REG_DIR;
            end
            gpio_pkg::PORT_E_PIN_DATA_ADDR: begin
                decode.port = gpio_pkg::PORT_E;
                decode.sel = gpio_pkg::REG_DATA;
            end
            default: decode.hit = 1'b0;
        endcase
    endfunction

    // pad synchroniser; stage one feeds stage two only
    logic [2:0][5:0] sync_a;
    logic [2:0][5:0] sync_b;
    logic [2:0][5:0] next_sync_a;
    logic [2:0][5:0] next_sync_b;

    // two plain stages: the pads are the only inputs from outside this clock
    always_comb begin
        next_sync_a = pin_in;
        next_sync_b = sync_a;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else if (ce) begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    // register file
    gpio_pkg::port_regs_s [2:0] regs;
    gpio_pkg::port_regs_s [2:0] next_regs;
    gpio_pkg::reg_hit_s hit;

    always_comb begin
        next_regs = regs;
        hit = decode(bus_req.addr);
        // reserved bits are dropped on write so they always read back zero
        if (bus_req.wr && hit.hit) begin
            case (hit.sel)
                gpio_pkg::REG_FSEL:
                    next_regs[hit.port].fsel = bus_req.wdata[5:0] & port_mask(hit.port); // [RQ1]
                gpio_pkg::REG_DIR:
                    next_regs[hit.port].dir = bus_req.wdata[5:0] & port_mask(hit.port); // [RQ2]
                gpio_pkg::REG_DATA:
                    next_regs[hit.port].data = bus_req.wdata[5:0] & port_mask(hit.port); // [RQ4]
                default: next_regs = regs;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            regs <= '0; // [RQ6]
        end else if (ce) begin
            regs <= next_regs;
        end
    end

    // read path, one cycle after the strobe; unmapped reads return zero
    logic [23:0] next_rdata;
    logic next_rvalid;
    logic [5:0] rd_view;

    always_comb begin
        next_rdata = gpio_pkg::REG_RESET;
        next_rvalid = bus_req.rd;
        rd_view = gpio_pkg::PIN_RESET;
        if (bus_req.rd && hit.hit) begin
            case (hit.sel)
                gpio_pkg::REG_FSEL: rd_view = regs[hit.port].fsel;
                gpio_pkg::REG_DIR: rd_view = regs[hit.port].dir;
                // gpio inputs show the pad, everything else the stored latch
                gpio_pkg::REG_DATA:
                    rd_view = (sync_b[hit.port] & ~regs[hit.port].fsel & ~regs[hit.port].dir)
                            | (regs[hit.port].data
                               & (regs[hit.port].fsel | regs[hit.port].dir)); // [RQ3]
                default: rd_view = gpio_pkg::PIN_RESET;
            endcase
            next_rdata = {18'h0_0000, rd_view & port_mask(hit.port)}; // [RQ7] [RQ8]
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_rdata <= gpio_pkg::REG_RESET;
            bus_rvalid <= 1'b0;
        end else if (ce) begin
            bus_rdata <= next_rdata;
            bus_rvalid <= next_rvalid;
        end
    end

    // pad and serial-unit muxing, registered so outputs come from flops
    logic [2:0][5:0] next_pin_out;
    logic [2:0][5:0] next_pin_oe_n;
    logic [2:0][5:0] next_periph_in;

    always_comb begin
        for (int p = 0; p < gpio_pkg::NPORT; p++) begin
            next_pin_out[p] = ((regs[p].fsel & periph_out[p])
                             | (~regs[p].fsel & regs[p].data)) & port_mask(2'(p)); // [RQ1] [RQ4]
            next_pin_oe_n[p] = ~(((regs[p].fsel & periph_oe[p])
                               | (~regs[p].fsel & regs[p].dir)) & port_mask(2'(p))); // [RQ2]
            next_periph_in[p] = sync_b[p] & regs[p].fsel; // [RQ1]
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_out <= '0;
            pin_oe_n <= '1; // [RQ6]
            periph_in <= '0;
        end else if (ce) begin
            pin_out <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
            periph_in <= next_periph_in;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_reset_all_clear: assert property ( // [RQ6]
        $past(rst) |-> (regs == '0 && pin_oe_n == '1 && pin_out == '0))
        else $error("registers or pads not cleared after reset");

    a_reserved_read_zero: assert property ( // [RQ7]
        bus_rvalid |-> bus_rdata[23:6] == 18'h0_0000)
        else $error("reserved read bits not zero");

    a_port_e_narrow: assert property ( // [RQ8]
        regs[2].fsel[5:3] == 3'h0 && regs[2].dir[5:3] == 3'h0 && pin_oe_n[2][5:3] == 3'h7)
        else $error("port e upper pins active");

    a_fsel_write_store: assert property ( // [RQ7]
        (ce && bus_req.wr && bus_req.addr == gpio_pkg::PORT_C_FUNCTION_SELECT_ADDR)
        |=> regs[0].fsel == $past(bus_req.wdata[5:0]))
        else $error("port c function select write lost");

    // the write and read strobes as taken on an enabled edge
    sequence s_take_write(logic [23:0] a);
        ce && bus_req.wr && bus_req.addr == a;
    endsequence

    sequence s_take_read;
        ce && bus_req.rd;
    endsequence

    a_dir_write_store: assert property ( // [RQ2]
        s_take_write(gpio_pkg::PORT_D_DIRECTION_ADDR)
        |=> regs[1].dir == $past(bus_req.wdata[5:0]))
        else $error("port d direction write lost");

    a_data_write_store: assert property ( // [RQ4]
        s_take_write(gpio_pkg::PORT_C_PIN_DATA_ADDR)
        |=> regs[0].data == $past(bus_req.wdata[5:0]))
        else $error("port c data write lost");

    a_narrow_data_store: assert property ( // [RQ8]
        s_take_write(gpio_pkg::PORT_E_PIN_DATA_ADDR)
        |=> regs[2].data == ($past(bus_req.wdata[5:0]) & gpio_pkg::NARROW_PORT_MASK))
        else $error("port e data write not cut to three pins");

    a_narrow_fsel_store: assert property ( // [RQ8]
        s_take_write(gpio_pkg::PORT_E_FUNCTION_SELECT_ADDR)
        |=> regs[2].fsel == ($past(bus_req.wdata[5:0]) & gpio_pkg::NARROW_PORT_MASK))
        else $error("port e function select write not cut to three pins");

    // a stray address must not disturb any port
    a_unmapped_write_ignore: assert property ( // [RQ7]
        (ce && bus_req.wr && !hit.hit) |=> regs == $past(regs))
        else $error("unmapped write changed a register");

    a_rvalid_follows_rd: assert property ( // [RQ3]
        ce |=> bus_rvalid == $past(bus_req.rd))
        else $error("read valid does not follow read strobe");

    a_unmapped_read_zero: assert property ( // [RQ8]
        (s_take_read ##0 !hit.hit) |=> bus_rvalid && bus_rdata == gpio_pkg::REG_RESET)
        else $error("unmapped read not zero");

    a_upper_data_clear: assert property ( // [RQ8]
        regs[2].data[5:3] == 3'h0 && pin_out[2][5:3] == 3'h0)
        else $error("port e upper data bits set");

    a_reset_bus_idle: assert property ( // [RQ6]
        $past(rst) |-> (!bus_rvalid && bus_rdata == gpio_pkg::REG_RESET
                        && periph_in == '0))
        else $error("bus or serial side not idle after reset");

    // ce low must hold the registers and read valid flag, pads included
    a_freeze_all: assert property ( // [RQ4]
        !ce |=> (regs == $past(regs) && pin_out == $past(pin_out)
                 && pin_oe_n == $past(pin_oe_n) && bus_rvalid == $past(bus_rvalid)))
        else $error("state moved while clock enable low");

    for (genvar g = 0; g < 3; g++) begin : g_chk
        sequence s_pad_steady;
            (ce && $stable(pin_in[g]))[*4];
        endsequence

        a_periph_route: assert property ( // [RQ1]
            ce |=> ((pin_out[g] ^ $past(periph_out[g])) & $past(regs[g].fsel)) == 6'h00)
            else $error("serial unit not routed to pad");

        a_gpio_direction: assert property ( // [RQ2]
            ce |=> (~pin_oe_n[g] & $past(~regs[g].fsel))
                   == $past(regs[g].dir & ~regs[g].fsel & port_mask(2'(g))))
            else $error("gpio direction wrong on pad");

        a_gpio_drive: assert property ( // [RQ4]
            ce |=> ((pin_out[g] ^ $past(regs[g].data)) & $past(regs[g].dir & ~regs[g].fsel))
                   == 6'h00)
            else $error("gpio output not driving latch");

        a_input_read_pad: assert property ( // [RQ3]
            (s_pad_steady ##0 (bus_req.rd && hit.hit
                && hit.port == 2'(g) && hit.sel == gpio_pkg::REG_DATA))
            |=> ((bus_rdata[5:0] ^ $past(pin_in[g]))
                 & $past(~regs[g].fsel & ~regs[g].dir) & port_mask(2'(g))) == 6'h00)
            else $error("gpio input read does not show pad");

        a_periph_enable: assert property ( // [RQ1]
            ce |=> ((~pin_oe_n[g] ^ $past(periph_oe[g])) & $past(regs[g].fsel)) == 6'h00)
            else $error("serial unit enable not routed to pad");

        a_periph_in_gate: assert property ( // [RQ1]
            ce |=> (periph_in[g] & ~$past(regs[g].fsel)) == 6'h00)
            else $error("gpio pin level leaks to serial unit");

        // the serial unit sees the pad three edges late, so it must sit still
        a_periph_in_pad: assert property ( // [RQ1]
            s_pad_steady
            |=> ((periph_in[g] ^ $past(pin_in[g])) & $past(regs[g].fsel)) == 6'h00)
            else $error("serial unit does not see pad level");

        // stored fields read back unchanged, pads do not enter here
        a_fsel_readback: assert property ( // [RQ1]
            (s_take_read ##0 (hit.hit && hit.port == 2'(g) && hit.sel == gpio_pkg::REG_FSEL))
            |=> bus_rdata[5:0] == $past(regs[g].fsel))
            else $error("function select reads back wrong");

        a_dir_readback: assert property ( // [RQ2]
            (s_take_read ##0 (hit.hit && hit.port == 2'(g) && hit.sel == gpio_pkg::REG_DIR))
            |=> bus_rdata[5:0] == $past(regs[g].dir))
            else $error("direction reads back wrong");

        a_output_readback: assert property ( // [RQ4]
            (s_take_read ##0 (hit.hit && hit.port == 2'(g) && hit.sel == gpio_pkg::REG_DATA))
            |=> ((bus_rdata[5:0] ^ $past(regs[g].data))
                 & $past(regs[g].fsel | regs[g].dir)) == 6'h00)
            else $error("output data latch reads back wrong");
    end
endmodule

//--- bench/pad_model.sv
module pad_model (
    // design pad side
    input wire logic [2:0][5:0] pin_out,
    input wire logic [2:0][5:0] pin_oe_n,
    // board side
    input wire logic [2:0][5:0] ext_level,
    output logic [2:0][5:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // the board drives every pad weakly, so the device wins wherever it drives
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule

//--- bench/shared_serial_pin_gpio_ports_tb.sv
module shared_serial_pin_gpio_ports_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    gpio_pkg::bus_req_s bus_req = '0;
    logic [23:0] bus_rdata;
    logic bus_rvalid;
    logic [2:0][5:0] pin_in, pin_out, pin_oe_n, periph_in;
    logic [2:0][5:0] periph_out = '0;
    logic [2:0][5:0] periph_oe = '0;
    logic [2:0][5:0] ext_level = '0;
    int n_mismatch = 0;
    int compares = 0;
    localparam logic [23:0] ADDRS [9] = '{gpio_pkg::PORT_C_FUNCTION_SELECT_ADDR,
        gpio_pkg::PORT_C_DIRECTION_ADDR, gpio_pkg::PORT_C_PIN_DATA_ADDR,
        gpio_pkg::PORT_D_FUNCTION_SELECT_ADDR, gpio_pkg::PORT_D_DIRECTION_ADDR,
        gpio_pkg::PORT_D_PIN_DATA_ADDR, gpio_pkg::PORT_E_FUNCTION_SELECT_ADDR,
        gpio_pkg::PORT_E_DIRECTION_ADDR, gpio_pkg::PORT_E_PIN_DATA_ADDR};
    shared_serial_pin_gpio_ports shared_serial_pin_gpio_ports_inst (
        .core_clk(core_clk), .rst(rst), .ce(ce), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .periph_out(periph_out),
        .periph_oe(periph_oe), .periph_in(periph_in));
    pad_model pad_model_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .ext_level(ext_level), .pin_in(pin_in));
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // upper bits always zero: positions 6-23 are never written with ones
    task automatic wr(input logic [23:0] addr, input logic [5:0] data);
        @(negedge core_clk);
        bus_req.addr = addr;
        bus_req.wdata = {18'h0_0000, data};
        bus_req.wr = 1'b1;
        @(negedge core_clk);
        bus_req.wr = 1'b0;
    endtask
    task automatic rd_chk(input string name, input logic [23:0] addr, input logic [23:0] exp);
        @(negedge core_clk);
        bus_req.addr = addr;
        bus_req.rd = 1'b1;
        @(negedge core_clk);
        bus_req.rd = 1'b0;
        chk({name, " valid"}, 24'(bus_rvalid), 24'h00_0001);
        chk(name, bus_rdata, exp);
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic s_reset();
        chk("oe_n after reset", 24'(pin_oe_n), 24'h03_ffff);
        chk("out after reset", 24'(pin_out), 24'h00_0000);
        for (int i = 0; i < 9; i++) rd_chk("reg reset", ADDRS[i], 24'h00_0000);
        rd_chk("unmapped", 24'h00_0000, 24'h00_0000);
    endtask
    task automatic s_input();
        ext_level[0] = 6'h15;
        wait_cycles(4);
        rd_chk("c input a", gpio_pkg::PORT_C_PIN_DATA_ADDR, 24'h00_0015);
        ext_level[0] = 6'h2a;
        wait_cycles(4);
        rd_chk("c input b", gpio_pkg::PORT_C_PIN_DATA_ADDR, 24'h00_002a);
    endtask
    task automatic s_output();
        wr(gpio_pkg::PORT_D_PIN_DATA_ADDR, 6'h2a);
        wr(gpio_pkg::PORT_D_DIRECTION_ADDR, 6'h3f);
        wait_cycles(2);
        chk("d oe_n", 24'(pin_oe_n[1]), 24'h00_0000);
        chk("d out", 24'(pin_out[1]), 24'h00_002a);
        rd_chk("d data", gpio_pkg::PORT_D_PIN_DATA_ADDR, 24'h00_002a);
        wr(gpio_pkg::PORT_D_DIRECTION_ADDR, 6'h01);
        wait_cycles(2);
        chk("d oe_n in", 24'(pin_oe_n[1]), 24'h00_003e);
    endtask
    task automatic s_serial();
        periph_out[0] = 6'h0c;
        periph_oe[0] = 6'h0f;
        ext_level[0] = 6'h33;
        wr(gpio_pkg::PORT_C_FUNCTION_SELECT_ADDR, 6'h3f);
        wait_cycles(5);
        chk("c ser oe_n", 24'(pin_oe_n[0]), 24'h00_0030);
        chk("c ser out", 24'(pin_out[0]), 24'h00_000c);
        chk("c ser in", 24'(periph_in[0]), 24'h00_003c);
        chk("d gpio in", 24'(periph_in[1]), 24'h00_0000);
    endtask
    task automatic s_port_e();
        // deliberately sets the reserved upper pins to see them dropped
        wr(gpio_pkg::PORT_E_PIN_DATA_ADDR, 6'h3f);
        wr(gpio_pkg::PORT_E_DIRECTION_ADDR, 6'h3f);
        wait_cycles(2);
        rd_chk("e dir", gpio_pkg::PORT_E_DIRECTION_ADDR, 24'h00_0007);
        chk("e oe_n", 24'(pin_oe_n[2]), 24'h00_0038);
        chk("e out", 24'(pin_out[2]), 24'h00_0007);
    endtask
    task automatic s_freeze();
        // ce low must swallow the write and hold the pads
        @(negedge core_clk);
        ce = 1'b0;
        wr(gpio_pkg::PORT_D_PIN_DATA_ADDR, 6'h15);
        wait_cycles(2);
        chk("d out frozen", 24'(pin_out[1]), 24'h00_002a);
        ce = 1'b1;
        wr(gpio_pkg::PORT_D_PIN_DATA_ADDR, 6'h15);
        wait_cycles(2);
        chk("d out after", 24'(pin_out[1]), 24'h00_0015);
    endtask
    task automatic s_mid_reset();
        @(negedge core_clk);
        rst = 1'b1;
        wait_cycles(2);
        rst = 1'b0;
        chk("oe_n mid rst", 24'(pin_oe_n), 24'h03_ffff);
        chk("out mid rst", 24'(pin_out), 24'h00_0000);
        chk("ser in mid rst", 24'(periph_in), 24'h00_0000);
        rd_chk("d dir rst", gpio_pkg::PORT_D_DIRECTION_ADDR, 24'h00_0000);
        rd_chk("c fsel rst", gpio_pkg::PORT_C_FUNCTION_SELECT_ADDR, 24'h00_0000);
        rd_chk("e dir rst", gpio_pkg::PORT_E_DIRECTION_ADDR, 24'h00_0000);
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        s_reset();
        s_input();
        s_output();
        s_serial();
        s_port_e();
        s_freeze();
        s_mid_reset();
        give_verdict();
    end
    initial begin
        #(25 * 2000);
        n_mismatch++;
        give_verdict();
    end
endmodule
